// File: apsoj_pkg.sv
// Package: constants and carriers for the rate-change and jog command block
// Functional notes
// - Rising command edge arms a position-triggered rate change on the chosen axis; the code arms it only in the accel phase.
// - Armed axis reaching trigger point in motion swaps speed for the new rate.
// - Rate change during deceleration or dwell is ignored, no error code.
// - Axis select zero is the first axis, one the second.
// - Axis select other than zero or one sets error flag, no action.
// - Rising jog edge moves chosen axis to target at configured jog speed.
// - Jog while moving gives code 401, while inhibited 402, no motion.
package apsoj_pkg;

  localparam int          APSOJ_NAXES    = 2;
  localparam logic [15:0] APSOJ_AX_FIRST = 16'h0000;
  localparam logic [15:0] APSOJ_AX_LAST  = 16'h0001;
  localparam logic [15:0] APSOJ_UNIT_POS = 16'h0000;
  localparam logic [31:0] APSOJ_RATE_MAX = 32'h000186a0;
  localparam logic [15:0] APSOJ_ERR_NONE = 16'h0000;
  localparam logic [15:0] APSOJ_ERR_BUSY = 16'h0191;
  localparam logic [15:0] APSOJ_ERR_INH  = 16'h0192;
  localparam logic [31:0] APSOJ_RST_W32  = 32'h00000000;

  typedef enum logic [1:0] {
    APSOJ_PH_IDLE  = 2'b00,
    APSOJ_PH_ACCEL = 2'b01,
    APSOJ_PH_DECEL = 2'b10,
    APSOJ_PH_DWELL = 2'b11
  } apsoj_phase_t;

  // Per-axis motion status from the pulse generator
  typedef struct packed {
    apsoj_phase_t phase;
    logic         inhibit;
    logic [31:0]  cur_pos;
  } apsoj_axis_stat_t;

  // Per-axis command toward the pulse generator
  typedef struct packed {
    logic         rate_load;
    logic [31:0]  rate;
    logic         jog_start;
    logic [31:0]  jog_target;
    logic [31:0]  jog_rate;
  } apsoj_axis_cmd_t;

endpackage

// File: apsoj_axis.sv
// Per-axis trigger watcher for the armed rate change
`timescale 1ns/100ps
module apsoj_axis
  import apsoj_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_ce,
  // Arming
  input  wire logic              i_arm,
  input  wire logic [31:0]       i_trig_pos,
  input  wire logic [31:0]       i_rate,
  input  wire apsoj_axis_stat_t  i_stat,
  // Result
  output logic                   o_armed,
  output logic                   o_fire,
  output logic [31:0]            o_rate
);

  logic        armed_r, armed_nxt;
  logic        up_r, up_nxt;
  logic [31:0] pos_r, pos_nxt;
  logic [31:0] rate_r, rate_nxt;
  logic        moving, reached;

  assign moving = (i_stat.phase != APSOJ_PH_IDLE);
  // Direction fixed at arming so the trigger is a crossing, not an equality
  assign reached = up_r ? ($signed(i_stat.cur_pos) >= $signed(pos_r))
                        : ($signed(i_stat.cur_pos) <= $signed(pos_r));

  always_comb begin
    armed_nxt = armed_r;
    up_nxt    = up_r;
    pos_nxt   = pos_r;
    rate_nxt  = rate_r;
    o_fire    = 1'b0;
    if (i_arm) begin
      armed_nxt = 1'b1;
      pos_nxt   = i_trig_pos;
      rate_nxt  = i_rate;
      up_nxt    = ($signed(i_trig_pos) >= $signed(i_stat.cur_pos));
    end else if (armed_r) begin
      if (!moving) begin
        armed_nxt = 1'b0;
      end else if (reached) begin
        o_fire    = 1'b1;
        armed_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      armed_r <= 1'b0;
      up_r    <= 1'b0;
      pos_r   <= APSOJ_RST_W32;
      rate_r  <= APSOJ_RST_W32;
    end else if (i_ce) begin
      armed_r <= armed_nxt;
      up_r    <= up_nxt;
      pos_r   <= pos_nxt;
      rate_r  <= rate_nxt;
    end
  end

  assign o_armed = armed_r;
  assign o_rate  = rate_r;

endmodule

// File: apsoj_top.sv
// Rate-change-at-position and jog command handling for two axes
`timescale 1ns/100ps
module apsoj_top
  import apsoj_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_ce,
  // Rate change command
  input  wire logic              i_rc_cond,
  input  wire logic [15:0]       i_rc_unit,
  input  wire logic [15:0]       i_rc_axis,
  input  wire logic [31:0]       i_rc_point,
  input  wire logic [31:0]       i_rc_rate,
  // Jog command
  input  wire logic              i_jog_cond,
  input  wire logic [15:0]       i_jog_unit,
  input  wire logic [15:0]       i_jog_axis,
  input  wire logic [31:0]       i_jog_point,
  // Configured jog speed per axis
  input  wire logic [31:0]       i_jog_rate0,
  input  wire logic [31:0]       i_jog_rate1,
  // Axis status
  input  wire apsoj_axis_stat_t  i_stat0,
  input  wire apsoj_axis_stat_t  i_stat1,
  // Axis commands
  output apsoj_axis_cmd_t        o_cmd0,
  output apsoj_axis_cmd_t        o_cmd1,
  // Status
  output logic                   o_instr_error_flag,
  output logic [15:0]            o_err_code0,
  output logic [15:0]            o_err_code1,
  output logic [1:0]             o_armed
);

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection

  logic rc_prev_r, rc_prev_nxt;
  logic jog_prev_r, jog_prev_nxt;
  logic rc_edge, jog_edge;

  assign rc_edge      = i_rc_cond && !rc_prev_r;
  assign jog_edge     = i_jog_cond && !jog_prev_r;
  assign rc_prev_nxt  = i_rc_cond;
  assign jog_prev_nxt = i_jog_cond;

  //////////////////////////////////////////////////////////////////////////////
  // Validation

  logic rc_ax_ok, jog_ax_ok;
  logic err_flag_r, err_flag_nxt;

  // Unit number is not checked; the issuer keeps it at zero
  assign rc_ax_ok  = (i_rc_axis <= APSOJ_AX_LAST);
  assign jog_ax_ok = (i_jog_axis <= APSOJ_AX_LAST);

  always_comb begin
    err_flag_nxt = err_flag_r;
    // Flag reflects the most recent command; cleared by a valid one
    if (rc_edge || jog_edge) begin
      err_flag_nxt = (rc_edge && !rc_ax_ok) || (jog_edge && !jog_ax_ok);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per axis

  apsoj_axis_stat_t stat [APSOJ_NAXES];
  logic [31:0]      jrate [APSOJ_NAXES];
  apsoj_axis_cmd_t  cmd_r [APSOJ_NAXES];
  apsoj_axis_cmd_t  cmd_nxt [APSOJ_NAXES];
  logic [15:0]      err_r [APSOJ_NAXES];
  logic [15:0]      err_nxt [APSOJ_NAXES];
  logic [1:0]       fire;
  logic [31:0]      frate [APSOJ_NAXES];

  assign stat[0]  = i_stat0;
  assign stat[1]  = i_stat1;
  assign jrate[0] = i_jog_rate0;
  assign jrate[1] = i_jog_rate1;

  genvar g;
  generate
    for (g = 0; g < APSOJ_NAXES; g++) begin : g_ax
      logic sel_rc, sel_jog, rc_ok_phase, arm;

      assign sel_rc  = rc_edge && rc_ax_ok && (i_rc_axis[0] == 1'(g));
      assign sel_jog = jog_edge && jog_ax_ok && (i_jog_axis[0] == 1'(g));
      // Arming is meaningless at rest, so only the accel phase arms
      assign rc_ok_phase = (stat[g].phase == APSOJ_PH_ACCEL);
      assign arm = sel_rc && rc_ok_phase;

      apsoj_axis u_axis (
        .i_clk      (i_clk),
        .i_nrst     (i_nrst),
        .i_ce       (i_ce),
        .i_arm      (arm),
        .i_trig_pos (i_rc_point),
        .i_rate     (i_rc_rate),
        .i_stat     (stat[g]),
        .o_armed    (o_armed[g]),
        .o_fire     (fire[g]),
        .o_rate     (frate[g])
      );

      always_comb begin
        cmd_nxt[g]           = cmd_r[g];
        cmd_nxt[g].rate_load = fire[g];
        cmd_nxt[g].jog_start = 1'b0;
        err_nxt[g]           = err_r[g];
        if (fire[g]) begin
          cmd_nxt[g].rate = frate[g];
        end
        if (sel_jog) begin
          if (stat[g].phase != APSOJ_PH_IDLE) begin
            err_nxt[g] = APSOJ_ERR_BUSY;
          end else if (stat[g].inhibit) begin
            err_nxt[g] = APSOJ_ERR_INH;
          end else begin
            err_nxt[g]            = APSOJ_ERR_NONE;
            cmd_nxt[g].jog_start  = 1'b1;
            cmd_nxt[g].jog_target = i_jog_point;
            cmd_nxt[g].jog_rate   = jrate[g];
          end
        end
      end

      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          cmd_r[g] <= '0;
          err_r[g] <= APSOJ_ERR_NONE;
        end else if (i_ce) begin
          cmd_r[g] <= cmd_nxt[g];
          err_r[g] <= err_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rc_prev_r  <= 1'b0;
      jog_prev_r <= 1'b0;
      err_flag_r <= 1'b0;
    end else if (i_ce) begin
      rc_prev_r  <= rc_prev_nxt;
      jog_prev_r <= jog_prev_nxt;
      err_flag_r <= err_flag_nxt;
    end
  end

  assign o_cmd0             = cmd_r[0];
  assign o_cmd1             = cmd_r[1];
  assign o_err_code0        = err_r[0];
  assign o_err_code1        = err_r[1];
  assign o_instr_error_flag = err_flag_r;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_edge_once;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && rc_edge) |=> !rc_edge;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge seen twice");

  property p_bad_axis;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && jog_edge && !rc_edge && !jog_ax_ok) |=> o_instr_error_flag;
  endproperty
  a_bad_axis: assert property (p_bad_axis) else $error("bad axis no flag");

  property p_bad_no_jog;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && jog_edge && !jog_ax_ok) |=> !o_cmd0.jog_start && !o_cmd1.jog_start;
  endproperty
  a_bad_no_jog: assert property (p_bad_no_jog) else $error("bad axis jogged");

  property p_jog_busy;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && g_ax[0].sel_jog && i_stat0.phase != APSOJ_PH_IDLE)
      |=> o_err_code0 == APSOJ_ERR_BUSY && !o_cmd0.jog_start;
  endproperty
  a_jog_busy: assert property (p_jog_busy) else $error("busy jog not refused");

  property p_jog_inh;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && g_ax[1].sel_jog && i_stat1.phase == APSOJ_PH_IDLE && i_stat1.inhibit)
      |=> o_err_code1 == APSOJ_ERR_INH && !o_cmd1.jog_start;
  endproperty
  a_jog_inh: assert property (p_jog_inh) else $error("inhibited jog not refused");

  property p_jog_go;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && g_ax[0].sel_jog && i_stat0.phase == APSOJ_PH_IDLE && !i_stat0.inhibit)
      |=> o_cmd0.jog_start && o_cmd0.jog_target == $past(i_jog_point)
          && o_cmd0.jog_rate == $past(i_jog_rate0);
  endproperty
  a_jog_go: assert property (p_jog_go) else $error("jog not started");

  property p_rc_ignored;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && g_ax[0].sel_rc && i_stat0.phase inside {APSOJ_PH_DECEL, APSOJ_PH_DWELL}
      && !o_armed[0] && !g_ax[0].sel_jog) |=> !o_armed[0] && $stable(o_err_code0);
  endproperty
  a_rc_ignored: assert property (p_rc_ignored) else $error("decel arm not ignored");

  property p_rc_arm;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && g_ax[1].sel_rc && i_stat1.phase == APSOJ_PH_ACCEL) |=> o_armed[1];
  endproperty
  a_rc_arm: assert property (p_rc_arm) else $error("rate change not armed");

  property p_rc_fire;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && fire[1]) |=> o_cmd1.rate_load && o_cmd1.rate == $past(frate[1]) && !o_armed[1];
  endproperty
  a_rc_fire: assert property (p_rc_fire) else $error("rate not loaded");

  c_jog:  cover property (@(posedge i_clk) disable iff (!i_nrst) o_cmd0.jog_start);
  c_fire: cover property (@(posedge i_clk) disable iff (!i_nrst) o_cmd1.rate_load);
  c_err:  cover property (@(posedge i_clk) disable iff (!i_nrst) o_instr_error_flag);

endmodule

// File: apsoj_axis_model.sv
// Behavioural axis pulse generator that answers the command block
`timescale 1ns/100ps
module apsoj_axis_model
  import apsoj_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // Scenario load
  input  wire logic              i_ld,
  input  wire apsoj_phase_t      i_ld_phase,
  input  wire logic              i_inh,
  input  wire logic [31:0]       i_ld_pos,
  input  wire logic [31:0]       i_ld_tgt,
  // Command in, status out
  input  wire apsoj_axis_cmd_t   i_cmd,
  output apsoj_axis_stat_t       o_stat
);
  apsoj_phase_t ph_r;
  logic [31:0]  pos_r;
  logic [31:0]  tgt_r;
  ////////////////////////////////////////////////////////////////////////////
  // One pulse a cycle; the commanded rate only matters to real hardware
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ph_r  <= APSOJ_PH_IDLE;
      pos_r <= 32'h00000000;
      tgt_r <= 32'h00000000;
    end else if (i_ld) begin
      ph_r  <= i_ld_phase;
      pos_r <= i_ld_pos;
      tgt_r <= i_ld_tgt;
    end else if (i_cmd.jog_start) begin
      ph_r  <= APSOJ_PH_ACCEL;
      tgt_r <= i_cmd.jog_target;
    end else if (ph_r == APSOJ_PH_ACCEL) begin
      if (pos_r == tgt_r) begin
        ph_r <= APSOJ_PH_IDLE;
      end else begin
        pos_r <= ($signed(pos_r) < $signed(tgt_r)) ? pos_r + 32'h1 : pos_r - 32'h1;
      end
    end
  end
  assign o_stat = {ph_r, i_inh, pos_r};
endmodule

// File: tb_apsoj_top.sv
// Self-checking bench for the rate-change and jog command block
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module tb_apsoj_top
  import apsoj_pkg::*;
;
  typedef struct packed {
    logic [15:0]  ax;
    apsoj_phase_t ph;
    logic         inh;
    logic [15:0]  err;
    logic         go;
    logic         flg;
  } apsoj_jrow_t;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic             ce = 1'b1;
  logic             rc_cond = 1'b0;
  logic [15:0]      rc_axis = 16'h0000;
  logic [31:0]      rc_point = 32'h00000000;
  logic [31:0]      rc_rate = 32'h00000000;
  logic             jog_cond = 1'b0;
  logic [15:0]      jog_axis = 16'h0000;
  logic [31:0]      jog_point = 32'hffffff6a;
  logic [31:0]      jog_rate [2] = '{32'h00000fa0, 32'h00001388};
  logic             ld [2] = '{1'b0, 1'b0};
  apsoj_phase_t     ld_ph [2] = '{APSOJ_PH_IDLE, APSOJ_PH_IDLE};
  logic             inh [2] = '{1'b0, 1'b0};
  apsoj_axis_stat_t stat0, stat1;
  apsoj_axis_cmd_t  cmd0, cmd1;
  logic             flag;
  logic [15:0]      err0, err1;
  logic [1:0]       armed;
  int               miscompares = 0;
  int               n_compared = 0;
  int               a;
  apsoj_jrow_t rows [9] = '{
    '{16'h0000, APSOJ_PH_ACCEL, 1'b0, APSOJ_ERR_BUSY, 1'b0, 1'b0},
    '{16'h0000, APSOJ_PH_DECEL, 1'b0, APSOJ_ERR_BUSY, 1'b0, 1'b0},
    '{16'h0000, APSOJ_PH_DWELL, 1'b0, APSOJ_ERR_BUSY, 1'b0, 1'b0},
    '{16'h0000, APSOJ_PH_IDLE,  1'b1, APSOJ_ERR_INH,  1'b0, 1'b0},
    '{16'h0001, APSOJ_PH_IDLE,  1'b1, APSOJ_ERR_INH,  1'b0, 1'b0},
    '{16'h0001, APSOJ_PH_IDLE,  1'b0, APSOJ_ERR_NONE, 1'b1, 1'b0},
    '{16'h0002, APSOJ_PH_IDLE,  1'b0, APSOJ_ERR_NONE, 1'b0, 1'b1},
    '{16'hffff, APSOJ_PH_IDLE,  1'b0, APSOJ_ERR_NONE, 1'b0, 1'b1},
    '{16'h0000, APSOJ_PH_IDLE,  1'b0, APSOJ_ERR_NONE, 1'b1, 1'b0}};
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  apsoj_axis_model i_apsoj_axis_model_0 (.i_clk(clk), .i_nrst(nrst), .i_ld(ld[0]),
    .i_ld_phase(ld_ph[0]), .i_inh(inh[0]), .i_ld_pos(32'h00000000),
    .i_ld_tgt(32'h00000064), .i_cmd(cmd0), .o_stat(stat0));
  apsoj_axis_model i_apsoj_axis_model_1 (.i_clk(clk), .i_nrst(nrst), .i_ld(ld[1]),
    .i_ld_phase(ld_ph[1]), .i_inh(inh[1]), .i_ld_pos(32'h00000000),
    .i_ld_tgt(32'h00000064), .i_cmd(cmd1), .o_stat(stat1));
  // Unit number held at zero by the issuer
  apsoj_top i_apsoj_top (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_rc_cond(rc_cond),
    .i_rc_unit(APSOJ_UNIT_POS), .i_rc_axis(rc_axis), .i_rc_point(rc_point),
    .i_rc_rate(rc_rate), .i_jog_cond(jog_cond), .i_jog_unit(APSOJ_UNIT_POS),
    .i_jog_axis(jog_axis), .i_jog_point(jog_point), .i_jog_rate0(jog_rate[0]),
    .i_jog_rate1(jog_rate[1]), .i_stat0(stat0), .i_stat1(stat1), .o_cmd0(cmd0),
    .o_cmd1(cmd1), .o_instr_error_flag(flag), .o_err_code0(err0), .o_err_code1(err1),
    .o_armed(armed));
  ////////////////////////////////////////////////////////////////////////////
  task automatic load(input int ax, input apsoj_phase_t ph, input logic ih);
    ld[ax] = 1'b1;
    ld_ph[ax] = ph;
    inh[ax] = ih;
    @(posedge clk);
    #1;
    ld[ax] = 1'b0;
  endtask
  // Leaves the condition high; caller lowers it after checking
  task automatic rc(input logic [15:0] ax, input logic [31:0] pt, input logic [31:0] rt);
    rc_axis = ax;
    rc_point = pt;
    rc_rate = rt;
    rc_cond = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    miscompares++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    foreach (rows[i]) begin
      a = rows[i].ax[0];
      load(a, rows[i].ph, rows[i].inh);
      jog_axis = rows[i].ax;
      jog_cond = 1'b1;
      @(posedge clk);
      #1;
      `CHK(flag, rows[i].flg)
      `CHK(cmd0.jog_start, rows[i].go & (a == 0))
      `CHK(cmd1.jog_start, rows[i].go & (a == 1))
      if (!rows[i].flg) `CHK(a ? err1 : err0, rows[i].err)
      if (rows[i].go) `CHK(a ? cmd1.jog_target : cmd0.jog_target, jog_point)
      if (rows[i].go) `CHK(a ? cmd1.jog_rate : cmd0.jog_rate, jog_rate[a])
      @(posedge clk);
      #1;
      `CHK(cmd0.jog_start | cmd1.jog_start, 1'b0)
      jog_cond = 1'b0;
      @(posedge clk);
      #1;
    end
    // Refused phases must leave no trace
    foreach (ld_ph[k]) begin
      load(0, k ? APSOJ_PH_DWELL : APSOJ_PH_DECEL, 1'b0);
      rc(16'h0000, 32'h0000000a, 32'h00003a98);
      `CHK(armed, 2'b00)
      `CHK(err0, APSOJ_ERR_NONE)
      rc_cond = 1'b0;
      @(posedge clk);
      #1;
    end
    rc(16'h0002, 32'h0000000a, 32'h00003a98);
    `CHK(flag, 1'b1)
    `CHK(armed, 2'b00)
    rc_cond = 1'b0;
    load(1, APSOJ_PH_ACCEL, 1'b0);
    rc(16'h0001, 32'h0000000a, APSOJ_RATE_MAX);
    `CHK(armed, 2'b10)
    `CHK(flag, 1'b0)
    rc_cond = 1'b0;
    for (int n = 0; n < 200 && cmd1.rate_load !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK(cmd1.rate_load, 1'b1)
    `CHK(cmd1.rate, APSOJ_RATE_MAX)
    `CHK(stat1.cur_pos, 32'h0000000b)
    `CHK(armed, 2'b00)
    `CHK(cmd0.rate_load, 1'b0)
    // Low enable freezes the edge detector, so the edge is taken later
    load(0, APSOJ_PH_IDLE, 1'b0);
    ce = 1'b0;
    jog_axis = 16'h0000;
    jog_cond = 1'b1;
    @(posedge clk);
    #1;
    `CHK(cmd0.jog_start, 1'b0)
    ce = 1'b1;
    @(posedge clk);
    #1;
    `CHK(cmd0.jog_start, 1'b1)
    // Mid-run reset with the condition held high
    nrst = 1'b0;
    #1;
    `CHK({cmd0, cmd1}, '0)
    `CHK({flag, err0, err1, armed}, '0)
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    @(posedge clk);
    #1;
    `CHK(cmd0.jog_start, 1'b1)
    @(posedge clk);
    #1;
    `CHK(cmd0.jog_start, 1'b0)
    jog_cond = 1'b0;
    results();
  end
endmodule
